// *** dv/dssr_drive_model.sv ***
`timescale 1ns/1ps
`default_nettype none

module dssr_drive_model
#(
  parameter logic [2:0] STS_CODE = 3'h2,
  parameter logic [2:0] HDR_CODE = 3'h4
)
(
  input  wire logic        clock,
  input  wire logic        arst_n,
  input  wire logic        cmd_stb,
  input  wire logic [2:0]  func,
  input  wire logic [7:0]  delay,
  input  wire logic [15:0] status_in,
  input  wire logic [15:0] hdr_in,
  input  wire logic [15:0] crc_in,
  output logic             resp,
  output logic      [15:0] status,
  output logic      [15:0] hdr,
  output logic      [15:0] crc
);
  int t_ff;

  // Answer after a delay, hold data well past the rise, then release
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      t_ff   <= 0;
      resp   <= 1'b0;
      status <= 16'h0000;
      hdr    <= 16'h0000;
      crc    <= 16'h0000;
    end
    else if (cmd_stb && (func == STS_CODE || func == HDR_CODE))
      t_ff <= 1;
    else if (t_ff != 0)
    begin
      t_ff <= t_ff + 1;
      if (t_ff == int'(delay))
      begin
        status <= status_in;
        hdr    <= hdr_in;
        crc    <= crc_in;
      end
      if (t_ff == int'(delay) + 1)
        resp <= 1'b1;
      if (t_ff == int'(delay) + 12)
      begin
        resp   <= 1'b0;
        status <= ~status;
        hdr    <= ~hdr;
        crc    <= ~crc;
        t_ff   <= 0;
      end
    end
  end
endmodule

`default_nettype wire

// *** dv/test_disk_silo_status_readout.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "dssr_params.svh"

module test_disk_silo_status_readout;
  localparam logic [2:0] STS = 3'h2;
  localparam logic [2:0] HDR = 3'h4;
  logic        clock;
  logic        arst_n;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic        pready;
  logic        pslverr;
  logic        drv_cmd_stb;
  logic        drv_resp;
  logic        func_done;
  logic [11:0] paddr;
  logic [11:0] drv_cmd_a;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic [2:0]  drv_func;
  logic [5:0]  drv_sector;
  logic [15:0] drv_status;
  logic [15:0] drv_hdr;
  logic [15:0] drv_crc;
  logic [15:0] m_status;
  logic [15:0] m_hdr;
  logic [15:0] m_crc;
  logic [7:0]  m_delay;
  int          bad_count;
  int          n_tests;
  int          stb_count;
  int          cycles;

  dssr_top #(.SILO_DEPTH(8), .GET_STATUS_CODE(STS), .READ_HEADER_CODE(HDR)) dut (
    .CLOCK(clock), .ARST_N(arst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .DRV_FUNC(drv_func), .DRV_CMD_STB(drv_cmd_stb), .DRV_CMD_A(drv_cmd_a),
    .DRV_SECTOR(drv_sector), .DRV_RESP(drv_resp), .DRV_STATUS(drv_status),
    .DRV_HDR(drv_hdr), .DRV_CRC(drv_crc), .FUNC_DONE(func_done));

  dssr_drive_model #(.STS_CODE(STS), .HDR_CODE(HDR)) drive (
    .clock(clock), .arst_n(arst_n), .cmd_stb(drv_cmd_stb), .func(drv_func),
    .delay(m_delay), .status_in(m_status), .hdr_in(m_hdr), .crc_in(m_crc),
    .resp(drv_resp), .status(drv_status), .hdr(drv_hdr), .crc(drv_crc));

  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  always @(posedge clock)
  begin
    cycles++;
    if (drv_cmd_stb === 1'b1)
      stb_count++;
    if (cycles == 20000)
    begin
      bad_count++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    if (bad_count == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     input logic [31:0] exp, input logic err, input string nm);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do
      @(posedge clock);
    while (pready !== 1'b1);
    chk({nm, " slverr"}, {31'h0, err}, {31'h0, pslverr});
    if (!wr)
      chk(nm, exp, prdata);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic run_op(input logic [2:0] code, input logic [15:0] s,
                        input logic [15:0] h, input logic [15:0] c);
    logic [11:0] w[6];
    int n;
    int s0;
    w = '{6{12'h000}};
    n = 0;
    s0 = stb_count;
    m_status <= s;
    m_hdr <= h;
    m_crc <= c;
    if (code == STS)
    begin
      n = 2;
      w[0] = {4'h0, s[7:0]};
      w[1] = {4'h0, s[15:8]};
    end
    if (code == HDR)
    begin
      n = 6;
      w = '{{4'h0, h[7:0]}, {4'h0, h[15:8]}, 12'h000, 12'h000, {4'h0, c[7:0]},
            {4'h0, c[15:8]}};
    end
    apb(1, `DSSR_OFS_CMD_A, {20'h0, 9'h0, code}, 0, 0, "cmd_a");
    apb(1, `DSSR_OFS_CMD_B, {20'h0, 9'h0A0, code}, 0, 0, "cmd_b");
    repeat (2) @(posedge clock);
    chk("strobe", 32'(s0 + 1), 32'(stb_count));
    chk("func", {29'h0, code}, {29'h0, drv_func});
    chk("cmd_a out", {29'h0, code}, {20'h0, drv_cmd_a});
    while (func_done !== 1'b1)
      @(posedge clock);
    apb(0, `DSSR_OFS_STATUS, 0, 32'((n << 4) | 1), 0, "status");
    for (int i = 0; i < n; i++)
      apb(0, `DSSR_OFS_SILO, 0, {20'h0, w[i]}, 0, "silo");
    apb(0, `DSSR_OFS_SILO, 0, 0, 0, "silo empty");
  endtask

  initial
  begin
    arst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    m_status = 16'h0000;
    m_hdr = 16'h0000;
    m_crc = 16'h0000;
    m_delay = 8'h02;
    repeat (20) @(posedge clock);
    arst_n <= 1'b1;
    apb(0, `DSSR_OFS_STATUS, 0, 32'h0000_0001, 0, "status rst");
    apb(0, `DSSR_OFS_CMD_B, 0, 32'h0000_0000, 0, "cmd_b rst");
    apb(0, `DSSR_OFS_SILO, 0, 32'h0000_0000, 0, "silo rst");
    apb(0, 12'h014, 0, 32'h0000_0000, 1, "unmapped");
    apb(1, `DSSR_OFS_SILO, 32'h0000_0055, 0, 1, "silo write");
    apb(1, `DSSR_OFS_SECTOR, 32'h0000_0015, 0, 0, "sector");
    @(posedge clock);
    chk("sector out", 32'h0000_0015, {26'h0, drv_sector});
    for (int i = 0; i < 8; i++)
      run_op(3'(i), 16'hC35A, 16'h9B2D, 16'h71E4);
    for (int i = 0; i < 8; i++)
      run_op(STS, {8'(1 << i), 5'(5'h15 ^ i), 3'(i)}, 16'h0, 16'h0);
    run_op(HDR, 16'h00FF, 16'hFF00, 16'h8001);
    m_delay <= 8'h28;
    apb(1, `DSSR_OFS_CMD_B, {29'h0, STS}, 0, 0, "busy start");
    apb(1, `DSSR_OFS_CMD_A, 32'h0000_0123, 0, 1, "busy write");
    apb(1, `DSSR_OFS_CMD_B, {29'h0, HDR}, 0, 1, "busy cmd_b");
    apb(0, `DSSR_OFS_STATUS, 0, 32'h0000_0002, 0, "busy status");
    chk("done low", 32'h0000_0000, {31'h0, func_done});
    while (func_done !== 1'b1)
      @(posedge clock);
    apb(0, `DSSR_OFS_CMD_A, 0, {29'h0, HDR}, 0, "cmd_a kept");
    apb(0, `DSSR_OFS_STATUS, 0, 32'h0000_0021, 0, "done status");
    give_verdict();
  end
endmodule

`default_nettype wire

// *** src/dssr_params.svh ***
`ifndef DSSR_PARAMS_SVH
`define DSSR_PARAMS_SVH

// Register byte offsets
`define DSSR_OFS_CMD_A      12'h000
`define DSSR_OFS_SECTOR     12'h004
`define DSSR_OFS_CMD_B      12'h008
`define DSSR_OFS_SILO       12'h00C
`define DSSR_OFS_STATUS     12'h010

// Reset values
`define DSSR_CMD_A_RST      12'h000
`define DSSR_SECTOR_RST     6'h00
`define DSSR_CMD_B_RST      12'h000

// Status register fields
`define DSSR_STAT_DONE_BIT  0
`define DSSR_STAT_BUSY_BIT  1
`define DSSR_STAT_CNT_LSB   4

// Drive status word, first byte fields
`define DSSR_W1_TYPE        7
`define DSSR_W1_HEAD        6
`define DSSR_W1_COVER       5
`define DSSR_W1_HOUT        4
`define DSSR_W1_BRUSH       3
`define DSSR_W1_STATE       0
// Drive status word, second byte position
`define DSSR_W2_LSB         8

// Last fill index per operation
`define DSSR_STS_LAST       3'h1
`define DSSR_HDR_LAST       3'h5

`endif

// *** src/dssr_pkg.sv ***
`default_nettype none

package dssr_pkg;
  typedef enum logic [1:0] {DSSR_IDLE, DSSR_WAIT, DSSR_FILL} dssr_state_e;
  typedef logic [11:0] dssr_word_t;
endpackage

`default_nettype wire

// *** src/dssr_top.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "dssr_params.svh"

module dssr_top
  import dssr_pkg::*;
#(
  parameter int         SILO_DEPTH       = 8,
  parameter logic [2:0] GET_STATUS_CODE  = 3'h2,
  parameter logic [2:0] READ_HEADER_CODE = 3'h4
)
(
  input  wire logic        CLOCK,
  input  wire logic        ARST_N,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [11:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  output logic      [2:0]  DRV_FUNC,
  output logic             DRV_CMD_STB,
  output logic      [11:0] DRV_CMD_A,
  output logic      [5:0]  DRV_SECTOR,
  input  wire logic        DRV_RESP,
  input  wire logic [15:0] DRV_STATUS,
  input  wire logic [15:0] DRV_HDR,
  input  wire logic [15:0] DRV_CRC,
  output logic             FUNC_DONE
);

  localparam int          PW      = (SILO_DEPTH > 1) ? $clog2(SILO_DEPTH) : 1;
  localparam logic [PW:0] DEPTH_C = (PW+1)'(SILO_DEPTH);

  function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
    ptr_inc = (p == PW'(SILO_DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  function automatic dssr_word_t fill_word(input logic hdr, input logic [2:0] idx,
                                           input logic [15:0] s, input logic [15:0] h,
                                           input logic [15:0] c);
    logic [7:0] b;
    b = 8'h00;
    if (hdr)
    begin
      case (idx)
        3'h0:    b = h[7:0];
        3'h1:    b = h[15:8];
        3'h4:    b = c[7:0];
        3'h5:    b = c[15:8];
        default: b = 8'h00;
      endcase
    end
    else if (idx == 3'h0)
    begin
      // Undefined upper bits read as zero
      b = {s[`DSSR_W1_TYPE],
           s[`DSSR_W1_HEAD],
           s[`DSSR_W1_COVER],
           s[`DSSR_W1_HOUT],
           s[`DSSR_W1_BRUSH],
           s[`DSSR_W1_STATE +: 3]};
    end
    else
    begin
      b = s[`DSSR_W2_LSB +: 8];
    end
    fill_word = {4'h0, b};
  endfunction

  logic [2:0]    resp_sync_ff;
  logic          resp_lvl_ff;
  logic          resp_rise;
  logic          setup;
  logic          access;
  logic          hit_a;
  logic          hit_s;
  logic          hit_b;
  logic          hit_silo;
  logic          hit_stat;
  logic          wr_go;
  logic          start;
  logic          pop;
  logic          push;
  logic          push_eff;
  logic [2:0]    func_in;
  logic [31:0]   rd_mux;
  dssr_word_t    push_word;
  dssr_word_t    head_word;
  logic [31:0]   prdata_ff;
  logic          pready_ff;
  logic          pslverr_ff;
  logic          pop_ok_ff;
  logic [11:0]   cmd_a_ff;
  logic [5:0]    sector_ff;
  logic [11:0]   cmd_b_ff;
  logic [2:0]    drv_func_ff;
  logic          drv_stb_ff;
  dssr_state_e   state_ff;
  logic [2:0]    fill_idx_ff;
  logic          hdr_op_ff;
  logic [15:0]   sts_q_ff;
  logic [15:0]   hdr_q_ff;
  logic [15:0]   crc_q_ff;
  logic          done_ff;
  dssr_word_t    silo_mem_ff [SILO_DEPTH];
  logic [PW-1:0] silo_wr_ff;
  logic [PW-1:0] silo_rd_ff;
  logic [PW:0]   silo_cnt_ff;

  // Response line synchroniser, change taken when stages two and three agree
  always_ff @(posedge CLOCK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      resp_sync_ff <= 3'h0;
      resp_lvl_ff  <= 1'b0;
    end
    else
    begin
      resp_sync_ff <= {resp_sync_ff[1:0], DRV_RESP};
      if (resp_sync_ff[1] == resp_sync_ff[2])
        resp_lvl_ff <= resp_sync_ff[2];
    end
  end

  assign resp_rise = (resp_sync_ff[1] == resp_sync_ff[2]) & resp_sync_ff[2] & ~resp_lvl_ff;

  // Bus decode
  assign setup    = PSEL & ~PENABLE;
  assign access   = PSEL & PENABLE & pready_ff;
  assign hit_a    = (PADDR == `DSSR_OFS_CMD_A);
  assign hit_s    = (PADDR == `DSSR_OFS_SECTOR);
  assign hit_b    = (PADDR == `DSSR_OFS_CMD_B);
  assign hit_silo = (PADDR == `DSSR_OFS_SILO);
  assign hit_stat = (PADDR == `DSSR_OFS_STATUS);
  assign wr_go    = access & PWRITE & ~pslverr_ff;
  assign start    = wr_go & hit_b;
  assign pop      = access & ~PWRITE & pop_ok_ff;
  assign func_in  = PWDATA[2:0];
  assign head_word = silo_mem_ff[silo_rd_ff];

  always_comb
  begin
    rd_mux = 32'h0000_0000;
    if (hit_a)
      rd_mux = {20'h0_0000, cmd_a_ff};
    else if (hit_s)
      rd_mux = {26'h000_0000, sector_ff};
    else if (hit_b)
      rd_mux = {20'h0_0000, cmd_b_ff};
    else if (hit_silo && (silo_cnt_ff != '0))
      rd_mux = {20'h0_0000, head_word};
    else if (hit_stat)
    begin
      rd_mux[`DSSR_STAT_DONE_BIT]         = done_ff;
      rd_mux[`DSSR_STAT_BUSY_BIT]         = (state_ff != DSSR_IDLE);
      rd_mux[`DSSR_STAT_CNT_LSB +: PW+1] = silo_cnt_ff;
    end
  end

  // Bus answer, one access cycle, registered
  always_ff @(posedge CLOCK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      prdata_ff  <= 32'h0000_0000;
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      pop_ok_ff  <= 1'b0;
    end
    else if (setup)
    begin
      pready_ff <= 1'b1;
      prdata_ff <= 32'h0000_0000;
      pop_ok_ff <= 1'b0;
      if (PWRITE)
        pslverr_ff <= ~((hit_a | hit_s | hit_b) & done_ff);
      else
      begin
        pslverr_ff <= ~(hit_a | hit_s | hit_b | hit_silo | hit_stat);
        prdata_ff  <= rd_mux;
        pop_ok_ff  <= hit_silo & (silo_cnt_ff != '0);
      end
    end
    else
    begin
      pready_ff <= 1'b0;
      pop_ok_ff <= 1'b0;
    end
  end

  // Software registers
  always_ff @(posedge CLOCK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      cmd_a_ff  <= `DSSR_CMD_A_RST;
      sector_ff <= `DSSR_SECTOR_RST;
      cmd_b_ff  <= `DSSR_CMD_B_RST;
    end
    else
    begin
      if (wr_go && hit_a)
        cmd_a_ff <= PWDATA[11:0];
      if (wr_go && hit_s)
        sector_ff <= PWDATA[5:0];
      if (start)
        cmd_b_ff <= PWDATA[11:0];
    end
  end

  // Command issue to the drive
  always_ff @(posedge CLOCK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      drv_stb_ff  <= 1'b0;
      drv_func_ff <= 3'h0;
    end
    else
    begin
      drv_stb_ff <= start;
      if (start)
        drv_func_ff <= func_in;
    end
  end

  // Operation sequencing
  always_ff @(posedge CLOCK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      state_ff    <= DSSR_IDLE;
      fill_idx_ff <= 3'h0;
      hdr_op_ff   <= 1'b0;
      sts_q_ff    <= 16'h0000;
      hdr_q_ff    <= 16'h0000;
      crc_q_ff    <= 16'h0000;
      done_ff     <= 1'b1;
    end
    else
    begin
      case (state_ff)
        DSSR_IDLE:
        begin
          if (start && (func_in == GET_STATUS_CODE || func_in == READ_HEADER_CODE))
          begin
            state_ff  <= DSSR_WAIT;
            hdr_op_ff <= (func_in == READ_HEADER_CODE);
            done_ff   <= 1'b0;
          end
        end
        DSSR_WAIT:
        begin
          if (resp_rise)
          begin
            sts_q_ff    <= DRV_STATUS;
            hdr_q_ff    <= DRV_HDR;
            crc_q_ff    <= DRV_CRC;
            fill_idx_ff <= 3'h0;
            state_ff    <= DSSR_FILL;
          end
        end
        DSSR_FILL:
        begin
          fill_idx_ff <= fill_idx_ff + 3'h1;
          if (fill_idx_ff == (hdr_op_ff ? `DSSR_HDR_LAST : `DSSR_STS_LAST))
          begin
            state_ff <= DSSR_IDLE;
            done_ff  <= 1'b1;
          end
        end
        default:
        begin
          state_ff <= DSSR_IDLE;
        end
      endcase
    end
  end

  assign push      = (state_ff == DSSR_FILL);
  assign push_word = fill_word(hdr_op_ff, fill_idx_ff, sts_q_ff, hdr_q_ff, crc_q_ff);
  assign push_eff  = push & (silo_cnt_ff != DEPTH_C);

  // Silo storage, cleared by each started operation
  always_ff @(posedge CLOCK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      for (int i = 0; i < SILO_DEPTH; i++)
        silo_mem_ff[i] <= 12'h000;
      silo_wr_ff  <= '0;
      silo_rd_ff  <= '0;
      silo_cnt_ff <= '0;
    end
    else if (start)
    begin
      silo_wr_ff  <= '0;
      silo_rd_ff  <= '0;
      silo_cnt_ff <= '0;
    end
    else
    begin
      if (push_eff)
      begin
        silo_mem_ff[silo_wr_ff] <= push_word;
        silo_wr_ff              <= ptr_inc(silo_wr_ff);
      end
      if (pop)
        silo_rd_ff <= ptr_inc(silo_rd_ff);
      case ({push_eff, pop})
        2'b10:   silo_cnt_ff <= silo_cnt_ff + 1'b1;
        2'b01:   silo_cnt_ff <= silo_cnt_ff - 1'b1;
        default: silo_cnt_ff <= silo_cnt_ff;
      endcase
    end
  end

  assign PRDATA      = prdata_ff;
  assign PREADY      = pready_ff;
  assign PSLVERR     = pslverr_ff;
  assign DRV_FUNC    = drv_func_ff;
  assign DRV_CMD_STB = drv_stb_ff;
  assign DRV_CMD_A   = cmd_a_ff;
  assign DRV_SECTOR  = sector_ff;
  assign FUNC_DONE   = done_ff;

  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!ARST_N);

  sequence s_sts_start;
    (state_ff == DSSR_WAIT) && resp_rise && !hdr_op_ff;
  endsequence
  sequence s_hdr_start;
    (state_ff == DSSR_WAIT) && resp_rise && hdr_op_ff;
  endsequence
  sequence s_six_push;
    push [*6] ##1 !push;
  endsequence

  AST_RD_SILO: assert property (setup && !PWRITE && hit_silo && silo_cnt_ff != '0
    |=> PRDATA == {20'h0_0000, $past(head_word)})
    else $error("silo read returned wrong word");
  AST_POP_ORDER: assert property (pop && !start |=> silo_rd_ff == ptr_inc($past(silo_rd_ff)))
    else $error("silo read pointer did not advance by one");
  AST_CNT_DROP: assert property (pop && !push_eff |=> silo_cnt_ff == $past(silo_cnt_ff) - 1)
    else $error("silo count did not drop on read");
  AST_STS_TWO: assert property (s_sts_start |=> push [*2] ##1 !push)
    else $error("status fill not two words");
  AST_HDR_SIX: assert property (s_hdr_start |=> s_six_push)
    else $error("header fill not six words");
  AST_W1: assert property (push && !hdr_op_ff && fill_idx_ff == 3'h0
    |-> push_word == {4'h0, sts_q_ff[7:0]})
    else $error("status word one wrong");
  AST_W2: assert property (push && !hdr_op_ff && fill_idx_ff == 3'h1
    |-> push_word == {4'h0, sts_q_ff[15:8]})
    else $error("status word two wrong");
  AST_HDR_ADDR: assert property (push && hdr_op_ff && fill_idx_ff == 3'h1
    |-> push_word == {4'h0, hdr_q_ff[15:8]})
    else $error("header address word wrong");
  AST_HDR_ZERO: assert property (push && hdr_op_ff && (fill_idx_ff == 3'h2 || fill_idx_ff == 3'h3)
    |-> push_word == 12'h000)
    else $error("header middle word not zero");
  AST_START: assert property (start |=> DRV_CMD_STB && DRV_FUNC == $past(func_in))
    else $error("function code not issued");
  AST_BUSY_ERR: assert property (setup && PWRITE && hit_b && !done_ff |=> PREADY && PSLVERR)
    else $error("load while busy not refused");
  AST_DONE: assert property (push && fill_idx_ff == (hdr_op_ff ? `DSSR_HDR_LAST : `DSSR_STS_LAST)
    |=> FUNC_DONE && state_ff == DSSR_IDLE)
    else $error("done not raised after fill");

endmodule

`default_nettype wire
